// ===== sct_pkg.sv
/*
 * Shared constants and types for the serial conversion-timing link:
 * frame layout, command codes, serial clock rates and sequencer timing.
 * Assumes both ends run on the same 4 ns system clock.
 */
package sct_pkg;
   localparam int CLK_NS     = 4;
   localparam int FRAME_BITS = 32;
   localparam int CNT_W      = 6;

   // Frame fields, most significant bit sent first.
   localparam int OP_MSB    = 31;
   localparam int OP_LSB    = 28;
   localparam int FAST_BIT  = 26;
   localparam int ACQ_LSB   = 0;
   localparam logic [3:0] OP_WRITE_CTRL = 4'h1;
   localparam logic [3:0] OP_CONVERT    = 4'h2;
   localparam logic [3:0] OP_READ       = 4'h3;
   localparam logic [1:0] ACQ_SEL_RST   = 2'h0;

   // Serial clock rates and the cycle counts derived from them.
   localparam int SCLK_SLOW_KHZ = 500;
   localparam int SCLK_FAST_KHZ = 725;
   localparam int HALF_SLOW_CYC =
      (1_000_000 + 2 * SCLK_SLOW_KHZ * CLK_NS - 1) / (2 * SCLK_SLOW_KHZ * CLK_NS);
   localparam int HALF_FAST_CYC =
      (1_000_000 + 2 * SCLK_FAST_KHZ * CLK_NS - 1) / (2 * SCLK_FAST_KHZ * CLK_NS);
   localparam int PER_SLOW_CYC =
      (1_000_000 + SCLK_SLOW_KHZ * CLK_NS - 1) / (SCLK_SLOW_KHZ * CLK_NS);
   localparam int PER_FAST_CYC =
      (1_000_000 + SCLK_FAST_KHZ * CLK_NS - 1) / (SCLK_FAST_KHZ * CLK_NS);

   // Chip select framing times of the host.
   localparam int CS_SETUP_NS  = 200;
   localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CS_HIGH_NS   = 400;
   localparam int CS_HIGH_CYC  = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;

   // Converter timing.
   localparam int ACQ0_NS  = 400;
   localparam int ACQ1_NS  = 800;
   localparam int ACQ2_NS  = 1600;
   localparam int ACQ3_NS  = 3200;
   localparam int ACQ0_CYC = (ACQ0_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACQ1_CYC = (ACQ1_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACQ2_CYC = (ACQ2_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACQ3_CYC = (ACQ3_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_NS  = 1040;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int START_NS     = 33_600;
   localparam int START_MIN_NS = 32_000;
   localparam int START_MAX_NS = 35_000;
   localparam int START_CYC    = START_NS / CLK_NS;
   localparam int HOP_NS   = 100;
   localparam int HOP_CYC  = HOP_NS / CLK_NS;
   localparam int TMR_W    = 14;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_ACQ, SEQ_CONV} sct_seq_t;
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_GAP} sct_hst_t;
endpackage

// ===== sct_if.sv
/*
 * Serial link between the host end and the device end.
 * Assumes the bench joins both modports. While the device releases the
 * data-out line, the line shows the inverse of the last bit, so a host
 * that samples a released line gets a wrong bit rather than a stale one.
 */
`timescale 1ns/100ps
`default_nettype none
interface sct_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo_d;
   logic sdo_oe_n;
   wire  sdo;

   assign sdo = sdo_oe_n ? ~sdo_d : sdo_d;

   modport host_mp (output cs_n, output sclk, output sdi, input sdo);
   modport dev_mp  (input cs_n, input sclk, input sdi,
                    output sdo_d, output sdo_oe_n);
endinterface
`default_nettype wire

// ===== sct_host.sv
/*
 * Host end: frames one 32-bit word per request, makes the serial clock
 * by dividing the system clock and captures the returned word.
 * Assumes the device end answers on the same interface.
 */
`timescale 1ns/100ps
`default_nettype none
module sct_host (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // Link
   sct_if.host_mp           link,
   // User side
   input  wire logic        start_i,
   input  wire logic [31:0] tx_word_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [31:0]      rx_word_o
);
   sct_pkg::sct_hst_t st_r;
   logic [9:0]  tmr_r;
   logic [9:0]  half_r;
   logic [5:0]  bit_r;
   logic [31:0] tx_r;
   logic [31:0] rx_r;
   logic [1:0]  sdo_sy;
   logic        fast_ok;

   // Fast clock only for writes and result reads, never register reads.
   assign fast_ok = tx_word_i[sct_pkg::FAST_BIT] &&
      (tx_word_i[sct_pkg::OP_MSB:sct_pkg::OP_LSB] != sct_pkg::OP_READ);
   assign busy_o  = (st_r != sct_pkg::H_IDLE);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sdo_sy <= 2'h0;
      end else begin
         sdo_sy <= {sdo_sy[0], link.sdo};
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_r      <= sct_pkg::H_IDLE;
         tmr_r     <= 10'h000;
         half_r    <= 10'h000;
         bit_r     <= 6'h00;
         tx_r      <= 32'h0000_0000;
         rx_r      <= 32'h0000_0000;
         rx_word_o <= 32'h0000_0000;
         done_o    <= 1'b0;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.sdi  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (tmr_r != 10'h000) begin
            tmr_r <= tmr_r - 10'h001;
         end
         unique case (st_r)
            sct_pkg::H_IDLE: if (start_i) begin
               half_r    <= fast_ok ? 10'(sct_pkg::HALF_FAST_CYC - 1)
                                    : 10'(sct_pkg::HALF_SLOW_CYC - 1);
               tx_r      <= {tx_word_i[30:0], 1'b0};
               link.sdi  <= tx_word_i[31];
               link.cs_n <= 1'b0;
               bit_r     <= 6'h00;
               tmr_r     <= 10'(sct_pkg::CS_SETUP_CYC - 1);
               st_r      <= sct_pkg::H_SETUP;
            end
            sct_pkg::H_SETUP, sct_pkg::H_LOW: if (tmr_r == 10'h000) begin
               if (bit_r == 6'(sct_pkg::FRAME_BITS)) begin
                  link.cs_n <= 1'b1;
                  rx_word_o <= rx_r;
                  done_o    <= 1'b1;
                  tmr_r     <= 10'(sct_pkg::CS_HIGH_CYC - 1);
                  st_r      <= sct_pkg::H_GAP;
               end else begin
                  link.sclk <= 1'b1;
                  // New data bit leaves at the rising edge, well clear
                  // of the falling edge where both ends sample.
                  if (bit_r != 6'h00) begin
                     link.sdi <= tx_r[31];
                     tx_r     <= {tx_r[30:0], 1'b0};
                  end
                  tmr_r <= half_r;
                  st_r  <= sct_pkg::H_HIGH;
               end
            end
            sct_pkg::H_HIGH: if (tmr_r == 10'h000) begin
               link.sclk <= 1'b0;
               rx_r      <= {rx_r[30:0], sdo_sy[1]};
               bit_r     <= bit_r + 6'h01;
               tmr_r     <= half_r;
               st_r      <= sct_pkg::H_LOW;
            end
            sct_pkg::H_GAP: if (tmr_r == 10'h000) begin
               st_r <= sct_pkg::H_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== sct_device.sv
/*
 * Device end: serial slave for 32-bit frames, daisy-chain forwarding
 * and the conversion sequencer with selectable acquisition time.
 * Assumes link pins are asynchronous to clk_sys_i and the host keeps
 * its own clock-rate and framing limits.
 */
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Two-bit select sets 400/800/1600/3200 ns acquisition.
// - First conversion 32 to 35 us after frame.
// - Forward chain signals with about 100 ns hop.
// - Host limits clock to 500 kHz with reads.
// - Fast flag allows 725 kHz, writes, results only.
// - Each frame is exactly 32 clocks, one select.
// - Data in sampled on falling serial clock edge.
// - Data out updated after each rising edge; the first rise here keeps the bit set at select.
// - Output driven while selected, released when deselected.
module sct_device #(
   parameter int START_CYC = sct_pkg::START_CYC,
   parameter int N_CH      = 8,
   parameter int HOP_CYC   = sct_pkg::HOP_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // Link
   sct_if.dev_mp            link,
   // Daisy-chain outputs toward the next device
   output logic             chain_cs_n_o,
   output logic             chain_sclk_o,
   output logic             chain_sdi_o,
   // Frame results
   input  wire logic [31:0] tx_word_i,
   output logic             rx_valid_o,
   output logic [31:0]      rx_word_o,
   output logic             frame_err_o,
   output logic             rate_err_o,
   // Conversion status
   output logic [1:0]       acq_sel_o,
   output logic             conv_start_o,
   output logic             acquiring_o,
   output logic             converting_o,
   output logic [7:0]       conv_chan_o
);
   logic [1:0]  cs_sy;
   logic [1:0]  sclk_sy;
   logic [1:0]  sdi_sy;
   logic        cs_q;
   logic        sclk_q;
   logic        cs_fall;
   logic        cs_rise;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        active;
   logic [5:0]  bit_r;
   logic [31:0] rx_sh_r;
   logic [31:0] tx_sh_r;
   logic [9:0]  per_r;
   logic [9:0]  per_min_r;
   logic        rise_seen_r;
   logic        frame_ok;
   logic [3:0]  op;
   logic        fast_ok;
   logic [9:0]  per_lim;
   sct_pkg::sct_seq_t seq_r;
   logic [sct_pkg::TMR_W-1:0] tmr_r;
   logic [HOP_CYC-1:0] fwd_cs_r;
   logic [HOP_CYC-1:0] fwd_sclk_r;
   logic [HOP_CYC-1:0] fwd_sdi_r;

   function automatic logic [sct_pkg::TMR_W-1:0] acq_cyc(input logic [1:0] s);
      logic [sct_pkg::TMR_W-1:0] c;
      c = sct_pkg::TMR_W'(sct_pkg::ACQ0_CYC);
      unique case (s)
         2'h0: c = sct_pkg::TMR_W'(sct_pkg::ACQ0_CYC);
         2'h1: c = sct_pkg::TMR_W'(sct_pkg::ACQ1_CYC);
         2'h2: c = sct_pkg::TMR_W'(sct_pkg::ACQ2_CYC);
         2'h3: c = sct_pkg::TMR_W'(sct_pkg::ACQ3_CYC);
      endcase
      return c;
   endfunction

   // Pins are synchronised; only the second stage feeds any logic.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cs_sy   <= 2'h3;
         sclk_sy <= 2'h0;
         sdi_sy  <= 2'h0;
         cs_q    <= 1'b1;
         sclk_q  <= 1'b0;
      end else begin
         cs_sy   <= {cs_sy[0], link.cs_n};
         sclk_sy <= {sclk_sy[0], link.sclk};
         sdi_sy  <= {sdi_sy[0], link.sdi};
         cs_q    <= cs_sy[1];
         sclk_q  <= sclk_sy[1];
      end
   end

   assign active    = ~cs_sy[1];
   assign cs_fall   = cs_q & ~cs_sy[1];
   assign cs_rise   = ~cs_q & cs_sy[1];
   assign sclk_rise = active & sclk_sy[1] & ~sclk_q;
   assign sclk_fall = active & ~sclk_sy[1] & sclk_q;

   // Receive: bits beyond the 32nd are dropped and mark a bad frame.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bit_r   <= 6'h00;
         rx_sh_r <= 32'h0000_0000;
      end else if (cs_fall) begin
         bit_r <= 6'h00;
      end else if (sclk_fall && bit_r <= 6'(sct_pkg::FRAME_BITS)) begin
         if (bit_r != 6'(sct_pkg::FRAME_BITS)) begin
            rx_sh_r <= {rx_sh_r[30:0], sdi_sy[1]};
         end
         bit_r <= bit_r + 6'h01;
      end
   end

   // Transmit: first bit stands from select, the rest follow rises.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tx_sh_r <= 32'h0000_0000;
      end else if (cs_fall) begin
         tx_sh_r <= tx_word_i;
      end else if (sclk_rise && bit_r != 6'h00) begin
         tx_sh_r <= {tx_sh_r[30:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         link.sdo_oe_n <= 1'b1;
         link.sdo_d    <= 1'b0;
      end else begin
         link.sdo_d <= tx_sh_r[31];
         if (cs_fall) begin
            link.sdo_oe_n <= 1'b0;
         end else if (cs_rise) begin
            link.sdo_oe_n <= 1'b1;
         end
      end
   end

   // Shortest serial clock period seen within the frame.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         per_r       <= 10'h000;
         per_min_r   <= 10'h3FF;
         rise_seen_r <= 1'b0;
      end else if (cs_fall) begin
         per_r       <= 10'h000;
         per_min_r   <= 10'h3FF;
         rise_seen_r <= 1'b0;
      end else if (sclk_rise) begin
         per_r       <= 10'h000;
         rise_seen_r <= 1'b1;
         if (rise_seen_r && per_r < per_min_r) begin
            per_min_r <= per_r;
         end
      end else if (per_r != 10'h3FF) begin
         per_r <= per_r + 10'h001;
      end
   end

   assign frame_ok = cs_rise && (bit_r == 6'(sct_pkg::FRAME_BITS));
   assign op       = rx_sh_r[sct_pkg::OP_MSB:sct_pkg::OP_LSB];
   assign fast_ok  = rx_sh_r[sct_pkg::FAST_BIT] && (op != sct_pkg::OP_READ);
   assign per_lim  = fast_ok ? 10'(sct_pkg::PER_FAST_CYC - 1)
                             : 10'(sct_pkg::PER_SLOW_CYC - 1);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rx_valid_o  <= 1'b0;
         rx_word_o   <= 32'h0000_0000;
         frame_err_o <= 1'b0;
         rate_err_o  <= 1'b0;
         acq_sel_o   <= sct_pkg::ACQ_SEL_RST;
      end else begin
         rx_valid_o  <= frame_ok;
         frame_err_o <= cs_rise & ~frame_ok;
         // No sync jitter is allowed: a period one cycle below the nominal is an error.
         rate_err_o  <= frame_ok && (per_min_r < per_lim);
         if (frame_ok) begin
            rx_word_o <= rx_sh_r;
         end
         if (frame_ok && op == sct_pkg::OP_WRITE_CTRL) begin
            acq_sel_o <= rx_sh_r[sct_pkg::ACQ_LSB +: 2];
         end
      end
   end

   // Conversion sequencer. A convert command while busy is ignored.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         seq_r        <= sct_pkg::SEQ_IDLE;
         tmr_r        <= '0;
         conv_chan_o  <= 8'h00;
         conv_start_o <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
         end
         unique case (seq_r)
            sct_pkg::SEQ_IDLE: if (frame_ok && op == sct_pkg::OP_CONVERT) begin
               tmr_r <= sct_pkg::TMR_W'(START_CYC - 1);
               seq_r <= sct_pkg::SEQ_WAIT;
            end
            sct_pkg::SEQ_WAIT: if (tmr_r == '0) begin
               conv_chan_o  <= 8'h00;
               conv_start_o <= 1'b1;
               tmr_r        <= acq_cyc(acq_sel_o) - 1'b1;
               seq_r        <= sct_pkg::SEQ_ACQ;
            end
            sct_pkg::SEQ_ACQ: if (tmr_r == '0) begin
               tmr_r <= sct_pkg::TMR_W'(sct_pkg::CONV_CYC - 1);
               seq_r <= sct_pkg::SEQ_CONV;
            end
            sct_pkg::SEQ_CONV: if (tmr_r == '0) begin
               if (conv_chan_o == 8'(N_CH - 1)) begin
                  seq_r <= sct_pkg::SEQ_IDLE;
               end else begin
                  conv_chan_o <= conv_chan_o + 8'h01;
                  tmr_r       <= acq_cyc(acq_sel_o) - 1'b1;
                  seq_r       <= sct_pkg::SEQ_ACQ;
               end
            end
         endcase
      end
   end

   assign acquiring_o  = (seq_r == sct_pkg::SEQ_ACQ);
   assign converting_o = (seq_r == sct_pkg::SEQ_CONV);

   // Chain hop: a fixed delay line on the synchronised pins.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         fwd_cs_r   <= '1;
         fwd_sclk_r <= '0;
         fwd_sdi_r  <= '0;
      end else begin
         fwd_cs_r   <= {fwd_cs_r[HOP_CYC-2:0], cs_sy[1]};
         fwd_sclk_r <= {fwd_sclk_r[HOP_CYC-2:0], sclk_sy[1]};
         fwd_sdi_r  <= {fwd_sdi_r[HOP_CYC-2:0], sdi_sy[1]};
      end
   end

   assign chain_cs_n_o = fwd_cs_r[HOP_CYC-1];
   assign chain_sclk_o = fwd_sclk_r[HOP_CYC-1];
   assign chain_sdi_o  = fwd_sdi_r[HOP_CYC-1];
endmodule
`default_nettype wire

// ===== sct_asserts.sv
/*
 * Concurrent checks on the host-to-device serial link and on the
 * device's conversion status outputs.
 * Assumes the bench wires it beside the link joining both design ends.
 */
`timescale 1ns/100ps
`default_nettype none
module sct_asserts (
   // Clock and reset
   input wire logic       clk_sys_i,
   input wire logic       rst_i,
   // Link
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       sdi,
   input wire logic       sdo_d,
   input wire logic       sdo_oe_n,
   // Device side
   input wire logic       chain_cs_n_o,
   input wire logic [1:0] acq_sel_o,
   input wire logic       conv_start_o,
   input wire logic       acquiring_o,
   input wire logic       converting_o
);
   logic [6:0]  rise_cnt;
   logic        sclk_q;
   logic [13:0] hi_cnt;
   logic [13:0] acq_cnt;
   logic [13:0] conv_cnt;
   int          acq_len;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // Rising serial clock edges seen while selected.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_q   <= 1'h0;
         rise_cnt <= 7'h00;
      end else begin
         sclk_q   <= sclk;
         rise_cnt <= cs_n ? 7'h00 : rise_cnt + 7'(sclk && !sclk_q);
      end
   end

   // Lengths of the clock high phase and of the converter phases.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         hi_cnt   <= 14'h0000;
         acq_cnt  <= 14'h0000;
         conv_cnt <= 14'h0000;
      end else begin
         hi_cnt   <= sclk ? hi_cnt + 14'h0001 : 14'h0000;
         acq_cnt  <= acquiring_o ? acq_cnt + 14'h0001 : 14'h0000;
         conv_cnt <= converting_o ? conv_cnt + 14'h0001 : 14'h0000;
      end
   end

   always_comb begin
      case (acq_sel_o)
         2'h0:    acq_len = sct_pkg::ACQ0_CYC;
         2'h1:    acq_len = sct_pkg::ACQ1_CYC;
         2'h2:    acq_len = sct_pkg::ACQ2_CYC;
         default: acq_len = sct_pkg::ACQ3_CYC;
      endcase
   end

   sequence cs_open;  $fell(cs_n); endsequence
   sequence cs_close; $rose(cs_n); endsequence
   sequence oe_on;    ##[1:5] !sdo_oe_n; endsequence
   sequence oe_off;   ##[1:5] sdo_oe_n; endsequence

   frame_bits_a: assert property (cs_close |-> rise_cnt == 7'h20)
      else $error("frame did not carry 32 clocks");
   oe_drive_a: assert property (cs_open |-> oe_on)
      else $error("data out not driven after select");
   oe_release_a: assert property (cs_close |-> oe_off)
      else $error("data out not released after deselect");
   sdo_update_a: assert property (
      $changed(sdo_d) && !cs_n && rise_cnt != 7'h00 |-> sclk)
      else $error("data out changed outside clock high phase");
   sdi_hold_a: assert property (
      $fell(sclk) && !cs_n |-> $stable(sdi) ##1 $stable(sdi))
      else $error("data in moved at sampling edge");
   clk_rate_a: assert property ($fell(sclk) |->
      hi_cnt == 14'(sct_pkg::HALF_SLOW_CYC) ||
      hi_cnt == 14'(sct_pkg::HALF_FAST_CYC))
      else $error("serial clock half period out of range");
   chain_hop_a: assert property (
      cs_open |-> ##[26:30] $fell(chain_cs_n_o))
      else $error("chain select not forwarded in time");
   acq_len_a: assert property ($fell(acquiring_o) |->
      converting_o && acq_cnt == 14'(acq_len))
      else $error("acquisition length wrong");
   conv_len_a: assert property (
      $fell(converting_o) |-> conv_cnt == 14'(sct_pkg::CONV_CYC))
      else $error("conversion length wrong");
   conv_first_a: assert property (
      conv_start_o |-> ##[0:1] acquiring_o && !converting_o)
      else $error("first conversion did not begin with acquisition");
endmodule
`default_nettype wire

// ===== spi_conversion_timing_bench.sv
/*
 * Self-checking bench: host and device joined on one link, plus a second
 * device fed by a bench driver that breaks the framing and clock rules.
 * Assumes START_CYC is shortened to keep the run short.
 */
`timescale 1ns/100ps
`default_nettype none
module spi_conversion_timing_bench;
   localparam int          ST_CYC = 40;
   localparam int          NCH    = 2;
   localparam logic [31:0] DEV_W  = 32'hA5C3_0F96;
   logic        clk_sys_i, rst_i, start, busy, done;
   logic [31:0] tx_word, h_rx, d_rx, b_rx;
   logic        d_rate, conv_start, acq, conv, ch_cs_n;
   logic        b_valid, b_ferr, b_rate, f_rate, f_bv, f_bf, f_br;
   logic        d_valid, d_ferr, f_dv, f_df, clr_f;
   logic [7:0]  chan;
   logic [1:0]  acq_sel, b_sel;
   int          miscompares = 0;
   int          n_tests = 0;

   sct_if u_link ();
   sct_if u_bad ();
   sct_host i_sct_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(u_link),
      .start_i(start), .tx_word_i(tx_word), .busy_o(busy), .done_o(done),
      .rx_word_o(h_rx));
   sct_device #(.START_CYC(ST_CYC), .N_CH(NCH)) i_sct_device (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(u_link),
      .chain_cs_n_o(ch_cs_n), .chain_sclk_o(), .chain_sdi_o(),
      .tx_word_i(DEV_W), .rx_valid_o(d_valid), .rx_word_o(d_rx),
      .frame_err_o(d_ferr),
      .rate_err_o(d_rate), .acq_sel_o(acq_sel), .conv_start_o(conv_start),
      .acquiring_o(acq), .converting_o(conv), .conv_chan_o(chan));
   sct_device #(.START_CYC(ST_CYC), .N_CH(NCH)) i_sct_device_2 (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(u_bad),
      .chain_cs_n_o(), .chain_sclk_o(), .chain_sdi_o(),
      .tx_word_i(32'h0000_0000), .rx_valid_o(b_valid), .rx_word_o(b_rx),
      .frame_err_o(b_ferr), .rate_err_o(b_rate), .acq_sel_o(b_sel),
      .conv_start_o(), .acquiring_o(), .converting_o(), .conv_chan_o());
   sct_asserts i_sct_asserts (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .cs_n(u_link.cs_n), .sclk(u_link.sclk), .sdi(u_link.sdi),
      .sdo_d(u_link.sdo_d), .sdo_oe_n(u_link.sdo_oe_n),
      .chain_cs_n_o(ch_cs_n), .acq_sel_o(acq_sel),
      .conv_start_o(conv_start), .acquiring_o(acq), .converting_o(conv));

   initial begin
      clk_sys_i = 1'h0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // Status pulses last one cycle, so they are caught in sticky flags.
   always @(posedge clk_sys_i) begin
      if (clr_f) begin
         {f_rate, f_bv, f_bf, f_br, f_dv, f_df} <= 6'h00;
      end else begin
         if (d_rate) f_rate <= 1'h1;
         if (b_valid) f_bv <= 1'h1;
         if (b_ferr) f_bf <= 1'h1;
         if (b_rate) f_br <= 1'h1;
         if (d_valid) f_dv <= 1'h1;
         if (d_ferr) f_df <= 1'h1;
      end
   end

   task automatic final_report;
      if (miscompares == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(inout int n, input int lim);
      @(negedge clk_sys_i);
      n++;
      if (n > lim) begin
         miscompares++;
         final_report();
      end
   endtask

   // Sends one word from the host and returns the first clock high width.
   task automatic send(input logic [31:0] w, output int hw);
      int n;
      n = 0;
      while (busy !== 1'h0) step(n, 1000);
      start   = 1'h1;
      tx_word = w;
      clr_f   = 1'h1;
      @(negedge clk_sys_i);
      start = 1'h0;
      clr_f = 1'h0;
      while (u_link.sclk !== 1'h1) step(n, 1000);
      hw = 0;
      while (u_link.sclk === 1'h1) step(hw, 400);
      n = 0;
      while (done !== 1'h1) step(n, 20000);
      repeat (10) @(negedge clk_sys_i);
      check(d_rx, w);
      check(h_rx, DEV_W);
      check(32'({f_dv, f_df}), 32'h0000_0002);
   endtask

   task automatic t_write_sels;
      logic [31:0] w;
      int          hw;
      for (int s = 0; s < 4; s++) begin
         w = {sct_pkg::OP_WRITE_CTRL, 2'h1, 24'h00_0000, 2'(s)};
         send(w, hw);
         check(32'(hw), 32'(sct_pkg::HALF_FAST_CYC));
         check(32'(f_rate), 32'h0000_0000);
         check(32'(acq_sel), 32'(s));
      end
   endtask

   task automatic t_convert;
      int hw;
      int n;
      int m;
      send({sct_pkg::OP_CONVERT, 2'h1, 26'h000_0000}, hw);
      n = 0;
      while (conv_start !== 1'h1) step(n, 200);
      // Counted from ten cycles after the select rose.
      check(32'(n >= ST_CYC - 8 && n <= ST_CYC), 32'h0000_0001);
      for (int ch = 0; ch < NCH; ch++) begin
         n = 0;
         while (acq !== 1'h1) step(n, 50);
         check(32'(chan), 32'(ch));
         n = 0;
         while (acq === 1'h1) step(n, 2000);
         check(32'(n), 32'(sct_pkg::ACQ3_CYC));
         m = 0;
         while (conv === 1'h1) step(m, 2000);
         check(32'(m), 32'(sct_pkg::CONV_CYC));
      end
      repeat (20) @(negedge clk_sys_i);
      check(32'({acq, conv}), 32'h0000_0000);
   endtask

   task automatic t_read;
      int hw;
      send({sct_pkg::OP_READ, 2'h1, 26'h000_0000}, hw);
      check(32'(hw), 32'(sct_pkg::HALF_SLOW_CYC));
   endtask

   // Bench-made 160 ns link clock, far above the device's limit.
   task automatic bad_frame(input int nbits, input logic [31:0] w);
      clr_f      = 1'h1;
      u_bad.cs_n = 1'h0;
      @(negedge clk_sys_i);
      clr_f = 1'h0;
      repeat (59) @(negedge clk_sys_i);
      // Data moves mid-way through the low phase, clear of the fall.
      for (int i = 0; i < nbits; i++) begin
         repeat (10) @(negedge clk_sys_i);
         u_bad.sdi = w[31 - i];
         repeat (10) @(negedge clk_sys_i);
         u_bad.sclk = 1'h1;
         repeat (20) @(negedge clk_sys_i);
         u_bad.sclk = 1'h0;
      end
      repeat (20) @(negedge clk_sys_i);
      u_bad.cs_n = 1'h1;
      u_bad.sdi  = ~u_bad.sdi;
      repeat (110) @(negedge clk_sys_i);
   endtask

   task automatic t_bad;
      logic [31:0] w;
      w = {sct_pkg::OP_WRITE_CTRL, 26'h000_0000, 2'h3};
      bad_frame(31, w);
      check(32'({f_bf, f_bv}), 32'h0000_0002);
      check(32'(b_sel), 32'h0000_0000);
      bad_frame(32, w);
      check(32'({f_bv, f_br}), 32'h0000_0003);
      check(b_rx, w);
   endtask

   initial begin
      rst_i      = 1'h1;
      start      = 1'h0;
      tx_word    = 32'h0000_0000;
      u_bad.cs_n = 1'h1;
      u_bad.sclk = 1'h0;
      u_bad.sdi  = 1'h0;
      clr_f      = 1'h1;
      repeat (4) @(negedge clk_sys_i);
      rst_i = 1'h0;
      clr_f = 1'h0;
      check(32'({u_link.cs_n, u_link.sdo_oe_n}), 32'h0000_0003);
      t_write_sels();
      t_convert();
      t_read();
      t_bad();
      final_report();
   end
endmodule
`default_nettype wire
